// ### logic/smmc_pkg.sv
// shared constants and types of the switch monitor mode control link
// assumes a 200 MHz system clock at both ends
package smmc_pkg;
  // clock and link timing
  localparam int CLK_KHZ = 200000;
  localparam int SCLK_MAX_KHZ = 3000;
  localparam int SCLK_HALF_CYC =
    (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam int DIV_W = 6;
  // polling and interrupt timer periods
  localparam int POLL_PERIOD_MS = 40;
  localparam int TIMER_PERIOD_MS = 1000;
  localparam int POLL_CYC = POLL_PERIOD_MS * CLK_KHZ;
  localparam int TIMER_CYC = TIMER_PERIOD_MS * CLK_KHZ;
  // serial frame
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam int MODE_W = 2;
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_POL_LSB = 2;
  localparam int RSP_MODE_LSB = 14;
  localparam int RSP_STAT_LSB = 2;
  localparam int RSP_IRQ_BIT = 1;
  // switch inputs
  localparam int NPROG = 4;
  localparam int NGND = 6;
  localparam int NBATT = 2;
  localparam int NSW = NPROG + NGND + NBATT;
  // host command port registers
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RXDATA = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int EV_W = 2;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_DEV_BIT = 1;

  typedef enum logic [MODE_W-1:0]
  {
    SMMC_SLEEP,
    SMMC_NORMAL,
    SMMC_POLL,
    SMMC_POLL_TMR
  } smmc_mode_e;
endpackage : smmc_pkg

// ### logic/smmc_if.sv
// serial link between host controller and switch monitor
// assumes the host always drives chip select; irq line has a pull-up
`timescale 1ns/100ps
interface smmc_if;
  logic sclk;
  logic mosi;
  logic cs_n;
  logic miso_o;
  logic miso_oe;
  logic irq_n_o;
  logic irq_n_oe;
  wire miso;
  wire irq_n;

  // resolved wire levels; a released data line shows the inverse
  // of its last bit, so a stray sample by the host shows up
  assign miso = miso_oe ? miso_o : !miso_o;
  assign irq_n = (irq_n_oe && !irq_n_o) ? 1'b0 : 1'b1;

  modport device
  (
    input sclk,
    input mosi,
    input cs_n,
    output miso_o,
    output miso_oe,
    output irq_n_o,
    output irq_n_oe
  );

  modport host
  (
    output sclk,
    output mosi,
    output cs_n,
    input miso,
    input irq_n
  );
endinterface : smmc_if

// ### logic/smmc_sync.sv
// two-flop synchroniser for a group of asynchronous levels
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module smmc_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_reg <= RST;
      q <= RST;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : smmc_sync

// ### logic/smmc_device.sv
// switch monitor device end: serial slave, mode control, monitoring
// assumes link pins and switch pins are asynchronous to clk
// Function
// - four modes, chosen by serial host writes
// - sleep stops monitoring, interrupt released
// - normal mode interrupts on any switch change
// - polling interrupts only on sensed closed switch
// - polling with timer also interrupts on expiry
// - reset pin forces sleep mode
// - interrupt output is open drain, low active
// - four programmable, six ground, two battery inputs
// - switch change wakes the polling device
// - serial access only while chip select low
// - one serial clock edge pair per bit
// - host keeps serial clock low when idle
// - role select pin sets master or slave
// - master drives sync to wake slaves
// - serial data output released when deselected
// - host serial clock at most 3 MHz
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module smmc_device
  import smmc_pkg::*;
#(
  parameter logic [31:0] POLL_CYCLES = 32'(POLL_CYC),
  parameter logic [31:0] TIMER_CYCLES = 32'(TIMER_CYC)
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link
  smmc_if.device link,
  // switch pins
  input wire logic [NPROG-1:0] prog_input,
  input wire logic [NGND-1:0] gnd_switch_in,
  input wire logic [NBATT-1:0] batt_switch_in,
  // control pins
  input wire logic reset_n_in,
  input wire logic role_select,
  // multi-device wake-up
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe
);
  // ==========================================================
  // input synchronisers
  logic [2:0] link_s;
  logic [NSW+2:0] pin_s;
  logic cs_s, sclk_s, mosi_s;
  logic rstpin_n_s, role_s, sync_s;
  logic [NPROG-1:0] prog_s;
  logic [NGND-1:0] gnd_s;
  logic [NBATT-1:0] batt_s;

  smmc_sync #(.W(3), .RST(3'h4)) u_link_sync
  (
    .clk(clk),
    .resetn(resetn),
    .d({link.cs_n, link.sclk, link.mosi}),
    .q(link_s)
  );

  smmc_sync #(.W(NSW + 3), .RST(15'h0000)) u_pin_sync
  (
    .clk(clk),
    .resetn(resetn),
    .d({reset_n_in, role_select, sync_in,
        batt_switch_in, gnd_switch_in, prog_input}),
    .q(pin_s)
  );

  assign cs_s = link_s[2];
  assign sclk_s = link_s[1];
  assign mosi_s = link_s[0];
  assign rstpin_n_s = pin_s[NSW+2];
  assign role_s = pin_s[NSW+1];
  assign sync_s = pin_s[NSW];
  assign batt_s = pin_s[NSW-1 -: NBATT];
  assign gnd_s = pin_s[NPROG +: NGND];
  assign prog_s = pin_s[NPROG-1:0];

  // ==========================================================
  // edge detection
  logic cs_d_reg, sclk_d_reg, sync_d_reg;
  logic cs_fall, cs_rise, sclk_rise, sclk_fall, sync_rise;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cs_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
      sync_d_reg <= 1'b0;
    end
    else
    begin
      cs_d_reg <= cs_s;
      sclk_d_reg <= sclk_s;
      sync_d_reg <= sync_s;
    end
  end

  assign cs_fall = !cs_s && cs_d_reg;
  assign cs_rise = cs_s && !cs_d_reg;
  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;
  assign sync_rise = sync_s && !sync_d_reg;

  // ==========================================================
  // serial shifter
  smmc_mode_e mode_reg;
  logic [NPROG-1:0] pol_reg;
  logic [NSW-1:0] closed_reg;
  logic irq_pend_reg;
  logic [FRAME_W-1:0] rx_reg;
  logic [FRAME_W-1:0] tx_reg;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic miso_oe_reg;
  logic [FRAME_W-1:0] response;

  assign response = {mode_reg, closed_reg, irq_pend_reg, 1'b0};

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_reg <= '0;
      tx_reg <= '0;
      bit_cnt_reg <= '0;
    end
    else if (cs_fall)
    begin
      tx_reg <= response;
      bit_cnt_reg <= '0;
    end
    else if (!cs_s)
    begin
      if (sclk_rise)
      begin
        rx_reg <= {rx_reg[FRAME_W-2:0], mosi_s};
        if (bit_cnt_reg != CNT_W'(FRAME_W))
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
      if (sclk_fall)
        tx_reg <= {tx_reg[FRAME_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      miso_oe_reg <= 1'b0;
    else
      miso_oe_reg <= !cs_s;
  end

  // ==========================================================
  // configuration
  always_ff @(posedge clk)
  begin
    if (!resetn || !rstpin_n_s)
    begin
      mode_reg <= SMMC_SLEEP;
      pol_reg <= '0;
    end
    else if (cs_rise && bit_cnt_reg == CNT_W'(FRAME_W))
    begin
      mode_reg <= smmc_mode_e'(rx_reg[CMD_MODE_LSB +: MODE_W]);
      pol_reg <= rx_reg[CMD_POL_LSB +: NPROG];
    end
  end

  // ==========================================================
  // monitoring
  logic [NSW-1:0] closed_now;
  logic is_poll, changed, wake;
  logic poll_tick, tmr_tick, sample_poll, event_any;
  logic [31:0] poll_cnt_reg, tmr_cnt_reg;

  // battery closed high, ground closed low
  assign closed_now = {batt_s, ~gnd_s, ~(prog_s ^ pol_reg)};
  assign is_poll = (mode_reg == SMMC_POLL) || (mode_reg == SMMC_POLL_TMR);
  assign changed = closed_now != closed_reg;
  assign wake = is_poll && (changed || (!role_s && sync_rise));
  assign poll_tick = is_poll && (poll_cnt_reg == POLL_CYCLES - 1'b1);
  assign tmr_tick = (mode_reg == SMMC_POLL_TMR)
    && (tmr_cnt_reg == TIMER_CYCLES - 1'b1);
  assign sample_poll = poll_tick || wake;
  assign event_any = ((mode_reg == SMMC_NORMAL) && changed)
    || (sample_poll && |closed_now) || tmr_tick;

  always_ff @(posedge clk)
  begin
    if (!resetn || mode_reg == SMMC_SLEEP)
      closed_reg <= '0;
    else if (mode_reg == SMMC_NORMAL || sample_poll)
      closed_reg <= closed_now;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn || !is_poll || sample_poll)
      poll_cnt_reg <= '0;
    else
      poll_cnt_reg <= poll_cnt_reg + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn || mode_reg != SMMC_POLL_TMR || event_any)
      tmr_cnt_reg <= '0;
    else
      tmr_cnt_reg <= tmr_cnt_reg + 1'b1;
  end

  // ==========================================================
  // interrupt, set wins over read clear
  always_ff @(posedge clk)
  begin
    if (!resetn || mode_reg == SMMC_SLEEP)
      irq_pend_reg <= 1'b0;
    else if (event_any)
      irq_pend_reg <= 1'b1;
    else if (cs_fall)
      irq_pend_reg <= 1'b0;
  end

  // ==========================================================
  // wake-up sync for slaves
  logic sync_out_reg, sync_oe_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sync_out_reg <= 1'b0;
      sync_oe_reg <= 1'b0;
    end
    else
    begin
      sync_out_reg <= role_s && sample_poll;
      sync_oe_reg <= role_s;
    end
  end

  // ==========================================================
  // outputs
  assign sync_out = sync_out_reg;
  assign sync_oe = sync_oe_reg;
  assign link.miso_o = tx_reg[FRAME_W-1];
  assign link.miso_oe = miso_oe_reg;
  assign link.irq_n_o = 1'b0;
  assign link.irq_n_oe = irq_pend_reg;
endmodule : smmc_device

// ### logic/smmc_host.sv
// host end: serial master driven from a simple command port
// assumes software waits for busy low before starting a frame
`timescale 1ns/100ps
module smmc_host
  import smmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link
  smmc_if.host link,
  // command port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // interrupt
  output logic irq
);
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_TAIL, H_GAP} smmc_hstate_e;

  // ==========================================================
  // input synchronisers
  logic [1:0] in_s;
  logic miso_s;
  logic dev_irq_s;

  smmc_sync #(.W(2), .RST(2'h1)) u_in_sync
  (
    .clk(clk),
    .resetn(resetn),
    .d({link.miso, link.irq_n}),
    .q(in_s)
  );

  assign miso_s = in_s[1];
  assign dev_irq_s = !in_s[0];

  // ==========================================================
  // frame sequencer
  smmc_hstate_e state_reg;
  logic [DIV_W-1:0] div_reg;
  logic [CNT_W-1:0] bit_reg;
  logic [FRAME_W-1:0] tx_reg;
  logic [FRAME_W-1:0] rx_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic tick;
  logic start;
  logic done;

  assign tick = div_reg == DIV_W'(SCLK_HALF_CYC - 1);
  assign start = wr && addr == ADDR_CTRL && state_reg == H_IDLE;
  assign done = state_reg == H_GAP && tick;

  always_ff @(posedge clk)
  begin
    if (!resetn || state_reg == H_IDLE || tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= H_IDLE;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      bit_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        H_IDLE:
        begin
          if (start)
          begin
            tx_reg <= wdata[FRAME_W-1:0];
            cs_n_reg <= 1'b0;
            bit_reg <= '0;
            state_reg <= H_SHIFT;
          end
        end
        H_SHIFT:
        begin
          if (tick && !sclk_reg)
          begin
            sclk_reg <= 1'b1;
            rx_reg <= {rx_reg[FRAME_W-2:0], miso_s};
          end
          else if (tick)
          begin
            sclk_reg <= 1'b0;
            tx_reg <= {tx_reg[FRAME_W-2:0], 1'b0};
            if (bit_reg == CNT_W'(FRAME_W - 1))
              state_reg <= H_TAIL;
            else
              bit_reg <= bit_reg + 1'b1;
          end
        end
        H_TAIL:
        begin
          if (tick)
          begin
            cs_n_reg <= 1'b1;
            state_reg <= H_GAP;
          end
        end
        H_GAP:
        begin
          if (tick)
            state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // events and mask, set wins over clear
  logic [EV_W-1:0] ev_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign ev_set = {dev_irq_s, done};
  assign ev_clr = (wr && addr == ADDR_IRQ_STAT) ? wdata[EV_W-1:0] : '0;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ev_reg <= '0;
    else
      ev_reg <= (ev_reg & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      mask_reg <= '0;
    else if (wr && addr == ADDR_IRQ_MASK)
      mask_reg <= wdata[EV_W-1:0];
  end

  // ==========================================================
  // read port, data valid only the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!resetn || !rd)
      rdata <= '0;
    else
    begin
      unique case (addr)
        ADDR_CTRL: rdata <= {16'h0000, tx_reg};
        ADDR_STATUS: rdata <= {30'h0, dev_irq_s,
                               state_reg != H_IDLE};
        ADDR_RXDATA: rdata <= {16'h0000, rx_reg};
        ADDR_IRQ_STAT: rdata <= {30'h0, ev_reg};
        ADDR_IRQ_MASK: rdata <= {30'h0, mask_reg};
        default: rdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign irq = |(ev_reg & mask_reg);
  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = tx_reg[FRAME_W-1];
endmodule : smmc_host

// ### bench/smmc_chk.sv
// link checker: timing and pin rules of the serial link
// assumes it is instantiated beside the link interface
`timescale 1ns/100ps
module smmc_chk
  import smmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link signals
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  input wire logic irq_n
);
  // ====================
  // helper counters
  logic [7:0] hi_cnt_reg;
  logic [7:0] lo_cnt_reg;
  logic [4:0] bit_cnt_reg;
  logic sclk_q_reg;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hi_cnt_reg <= '0;
      lo_cnt_reg <= '0;
      bit_cnt_reg <= '0;
      sclk_q_reg <= 1'b0;
    end
    else
    begin
      hi_cnt_reg <= sclk ? hi_cnt_reg + 8'h1 : 8'h0;
      lo_cnt_reg <= (!sclk && !cs_n) ? lo_cnt_reg + 8'h1 : 8'h0;
      bit_cnt_reg <= cs_n ? 5'h0
        : bit_cnt_reg + 5'(sclk && !sclk_q_reg);
      sclk_q_reg <= sclk;
    end
  end
  // ====================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_idle_low;
    cs_n |-> !sclk;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("serial clock high while deselected");
  property p_lead;
    $fell(cs_n) |-> !sclk [*8];
  endproperty
  a_lead: assert property (p_lead)
    else $error("serial clock not low after select");
  property p_high;
    $fell(sclk) |-> hi_cnt_reg == SCLK_HALF_CYC;
  endproperty
  a_high: assert property (p_high)
    else $error("serial clock high phase wrong");
  property p_low;
    $rose(sclk) |-> lo_cnt_reg == SCLK_HALF_CYC;
  endproperty
  a_low: assert property (p_low)
    else $error("serial clock low phase wrong");
  property p_bits;
    $rose(cs_n) |-> bit_cnt_reg == 5'h10;
  endproperty
  a_bits: assert property (p_bits)
    else $error("frame bit count wrong");
  property p_mosi;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosi: assert property (p_mosi)
    else $error("data changed while clock high");
  property p_release;
    cs_n [*5] |-> !miso_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("data out driven while deselected");
  property p_sel;
    $rose(miso_oe) |-> !cs_n;
  endproperty
  a_sel: assert property (p_sel)
    else $error("data out enabled without select");
  property p_od;
    irq_n_oe |-> !irq_n_o && !irq_n;
  endproperty
  a_od: assert property (p_od)
    else $error("interrupt line not pulled low");
endmodule : smmc_chk

// ### bench/tb_top.sv
// testbench: host and device ends joined by the link interface
// assumes short poll and timer counts set at the device instance
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      n_errors++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
  end
module tb_top
  import smmc_pkg::*;
;
  typedef struct packed {logic [15:0] cmd; logic [11:0] sw; logic irq;}
    smmc_row_s;
  // switch vector is {batt[1:0], gnd[5:0], prog[3:0]}
  localparam smmc_row_s ROWS [5] = '{'{16'h0000, 12'h3EF, 1'b0},
    '{16'h0001, 12'h3EF, 1'b1}, '{16'h003D, 12'h3F4, 1'b1},
    '{16'h0002, 12'hBFF, 1'b1}, '{16'h0003, 12'h1FF, 1'b1}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [11:0] sw = 12'h3FF;
  logic reset_n_in = 1'b1;
  logic role_select = 1'b0;
  logic sync_in = 1'b0;
  logic sync_out;
  logic sync_oe;
  logic [31:0] rx;
  logic [31:0] st;
  int n_errors = 0;
  int checked = 0;
  int n;
  always #2.5 clk = ~clk;
  // ====================
  // ends and checker
  smmc_if u_smmc_if ();
  smmc_host u_smmc_host (.clk(clk), .resetn(resetn),
    .link(u_smmc_if.host), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq));
  smmc_device #(.POLL_CYCLES(32'h7D0), .TIMER_CYCLES(32'h1770))
    u_smmc_device (.clk(clk), .resetn(resetn), .link(u_smmc_if.device),
    .prog_input(sw[3:0]), .gnd_switch_in(sw[9:4]),
    .batt_switch_in(sw[11:10]), .reset_n_in(reset_n_in),
    .role_select(role_select), .sync_in(sync_in), .sync_out(sync_out),
    .sync_oe(sync_oe));
  smmc_chk u_smmc_chk (.clk(clk), .resetn(resetn), .sclk(u_smmc_if.sclk),
    .mosi(u_smmc_if.mosi), .cs_n(u_smmc_if.cs_n),
    .miso_oe(u_smmc_if.miso_oe), .irq_n_o(u_smmc_if.irq_n_o),
    .irq_n_oe(u_smmc_if.irq_n_oe), .irq_n(u_smmc_if.irq_n));
  // ====================
  // tasks
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data stand in the cycle after the strobe only
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic frame(input logic [15:0] c);
    int k;
    wr_reg(ADDR_CTRL, {16'h0, c});
    k = 0;
    st = 32'h1;
    while (st[STAT_BUSY_BIT] !== 1'b0 && k < 3000)
    begin
      rd_reg(ADDR_STATUS, st);
      k++;
    end
    `CHK(st[STAT_BUSY_BIT], 1'b0)
    rd_reg(ADDR_RXDATA, rx);
  endtask : frame
  function automatic logic [15:0] exp_rsp(logic [15:0] c, logic [11:0] s,
    logic i);
    logic [11:0] cl;
    cl = {s[11:10], ~s[9:4], ~(s[3:0] ^ c[5:2])};
    if (c[1:0] == 2'h0)
      cl = 12'h0;
    return {c[1:0], cl, i, 1'b0};
  endfunction : exp_rsp
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  // ====================
  // main sequence
  initial
  begin
    tick(5);
    resetn <= 1'b1;
    `CHK(u_smmc_if.cs_n, 1'b1)
    `CHK(u_smmc_if.sclk, 1'b0)
    `CHK(u_smmc_if.miso_oe, 1'b0)
    `CHK(u_smmc_if.irq_n, 1'b1)
    tick(5);
    for (int i = 0; i < 5; i++)
    begin
      sw <= {2'h0, 6'h3F, ~ROWS[i].cmd[5:2]};
      tick(20);
      frame(ROWS[i].cmd);
      sw <= ROWS[i].sw;
      tick(300);
      rd_reg(ADDR_STATUS, st);
      `CHK(st[STAT_IRQ_BIT], ROWS[i].irq)
      `CHK(u_smmc_if.irq_n, !ROWS[i].irq)
      frame(ROWS[i].cmd);
      `CHK(rx[15:0], exp_rsp(ROWS[i].cmd, ROWS[i].sw, ROWS[i].irq))
    end
    // timer expiry with every switch open
    sw <= 12'h3FF;
    tick(20);
    frame(16'h0003);
    n = 0;
    while (u_smmc_if.irq_n !== 1'b0 && n < 6500)
    begin
      tick(1);
      n++;
    end
    `CHK(u_smmc_if.irq_n, 1'b0)
    // opening a switch in polling mode stays quiet
    frame(16'h0002);
    sw <= 12'h3EF;
    tick(20);
    frame(16'h0002);
    sw <= 12'h3FF;
    tick(300);
    rd_reg(ADDR_STATUS, st);
    `CHK(st[STAT_IRQ_BIT], 1'b0)
    reset_n_in <= 1'b0;
    tick(10);
    reset_n_in <= 1'b1;
    tick(10);
    frame(16'h0001);
    `CHK(rx[15:14], 2'h0)
    role_select <= 1'b1;
    frame(16'h0002);
    tick(10);
    `CHK(sync_oe, 1'b1)
    n = 0;
    repeat (4000)
    begin
      tick(1);
      if (sync_out === 1'b1)
        n++;
    end
    `CHK(n, 2)
    role_select <= 1'b0;
    tick(10);
    `CHK(sync_oe, 1'b0)
    // slave resamples on a sync rise with a switch held closed
    sw <= 12'h3EF;
    tick(20);
    frame(16'h0002);
    sync_in <= 1'b1;
    tick(10);
    rd_reg(ADDR_STATUS, st);
    `CHK(st[STAT_IRQ_BIT], 1'b1)
    sync_in <= 1'b0;
    // host event flags, mask and unmapped read
    rd_reg(ADDR_IRQ_MASK, st);
    `CHK(st, 32'h0)
    wr_reg(ADDR_IRQ_MASK, 32'h1);
    tick(2);
    `CHK(irq, 1'b1)
    wr_reg(ADDR_IRQ_STAT, 32'h1);
    tick(2);
    `CHK(irq, 1'b0)
    rd_reg(8'h14, st);
    `CHK(st, 32'h0)
    resetn <= 1'b0;
    tick(5);
    `CHK(u_smmc_if.miso_oe, 1'b0)
    `CHK(irq, 1'b0)
    resetn <= 1'b1;
    tick(5);
    frame(16'h0000);
    `CHK(rx[15:14], 2'h0)
    test_done;
  end
  initial
  begin
    #400000;
    n_errors++;
    test_done;
  end
endmodule : tb_top
